// ==== rtl/pwm_reload_pkg.sv ====
/*
 Constants shared by the PWM reload and fault protection block:
 register offsets, field positions, reset values and counts.
 Assumes a 32-bit APB register bus with byte addresses.
*/
`default_nettype none
package pwm_reload_pkg;
   // Sizes of the block
   localparam int unsigned NUM_GEN   = 3;   // Reload flag groups
   localparam int unsigned NUM_PIN   = 6;   // PWM output pins
   localparam int unsigned NUM_FAULT = 4;   // Fault inputs
   localparam int unsigned MAP_BITS  = 4;   // Mapping bits per pin
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL  = 8'h00; // Generator control
   localparam logic [7:0] OFS_RFLAG = 8'h04; // Reload flags, w1c
   localparam logic [7:0] OFS_MOD   = 8'h08; // Modulus buffer
   localparam logic [7:0] OFS_CNT   = 8'h0c; // Counter, read only
   localparam logic [7:0] OFS_VAL0  = 8'h10; // Value buffers 0..5
   localparam logic [7:0] OFS_FCTL  = 8'h28; // Fault control
   localparam logic [7:0] OFS_FFLAG = 8'h2c; // Fault flags, w1c
   localparam logic [7:0] OFS_DMAP  = 8'h30; // Disable mapping
   localparam logic [7:0] OFS_OCTL  = 8'h34; // Software outputs
   // Control register fields
   localparam int unsigned CTRL_EN       = 0;  // generator_enable
   localparam int unsigned CTRL_LOAD_OKAY     = 1;  // load_okay
   localparam int unsigned CTRL_HALF     = 2;  // Half-cycle reload
   localparam int unsigned CTRL_CENTER   = 3;  // Center-aligned
   localparam int unsigned CTRL_LOAD_FREQUENCY_SEL_LSB = 4;  // load_frequency_sel
   localparam int unsigned CTRL_PRSC_LSB = 8;  // Prescaler select
   localparam int unsigned CTRL_RIE_LSB  = 10; // reload_irq_en
   localparam int unsigned CTRL_CORR     = 13; // Current correction
   // Fault control, fault flag and output control fields
   localparam int unsigned FCTL_PINEN_LSB = 0;  // fault_pin_enable
   localparam int unsigned FCTL_FIE_LSB   = 4;  // fault_irq_en
   localparam int unsigned FCTL_AUTO_LSB  = 8;  // fault_auto_clear
   localparam int unsigned FCTL_QUAL_LSB  = 12; // fault_filter_qual
   localparam int unsigned FFLAG_LVL_LSB  = 4;  // Filtered levels
   localparam int unsigned OCTL_LVL_LSB   = 8;  // sw_output_level
   // Reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] MOD_RST  = 32'h0000_0100;
   localparam logic [31:0] REG_RST  = 32'h0000_0000;
   // Fault filter sampling
   localparam logic [1:0] SAMPLE_LAST = 2'h3; // Every four cycles
endpackage
`default_nettype wire

// ==== rtl/fault_filter.sv ====
/*
 Sample filter for one fault input: two-flop synchroniser,
 sampling once every four cycles, consecutive-one qualifier.
 Assumes the pin is asynchronous to clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module fault_filter
   import pwm_reload_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       ce_in,
   input  wire logic       enable_in,
   input  wire logic [1:0] qual_in,
   input  wire logic       pin_in,
   output logic            fault_out
);
   logic       sync1_q;  // First synchroniser stage
   logic       sync2_q;  // Second synchroniser stage
   logic [1:0] div_q;    // Sample spacing counter
   logic [2:0] run_q;    // Consecutive high samples
   logic [2:0] need;     // Samples needed to qualify

   assign need = {1'b0, qual_in} + 3'h1;

   // Synchroniser, read only through the second stage
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else if (ce_in) begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
      end
   end

   // Sample filter and fault decision
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         div_q     <= 2'h0;
         run_q     <= 3'h0;
         fault_out <= 1'b0;
      end else if (ce_in) begin
         div_q <= div_q + 2'h1;
         if (!enable_in) begin
            run_q     <= 3'h0;
            fault_out <= 1'b0;
         end else if (qual_in == 2'h0) begin
            fault_out <= sync2_q;               // Unfiltered level
         end else if (div_q == SAMPLE_LAST) begin
            if (!sync2_q) begin
               run_q     <= 3'h0;
               fault_out <= 1'b0;
            end else if (run_q + 3'h1 >= need) begin
               run_q     <= need;
               fault_out <= 1'b1;
            end else begin
               run_q <= run_q + 3'h1;
            end
         end
      end
   end
endmodule // fault_filter
`default_nettype wire

// ==== rtl/pwm_reload_and_fault_protect.sv ====
/*
 PWM timebase with reload scheduling, reload flags, enable and
 initialisation behaviour, output pin control and fault protection,
 with an APB register slave. Assumes one clock, synchronous reset,
 fault pins asynchronous and active high.
*/
// Our own choices: the register addresses and the APB register port.
// Summary of operation
// - Reload once every 1 to 16 opportunities
// - Frequency setting taken at every opportunity
// - Center half mode: opportunity also at modulus
// - Otherwise opportunities only at cycle start
// - Half-cycle modulus load forces count modulus-1
// - Each reload sets the reload flag
// - Reload flag requests interrupt when enabled
// - Enable sets flag; loads buffers if okay
// - First enable without okay: divide one, zero
// - Re-enable without okay keeps last parameters
// - Odd values drive pairs in first cycle
// - Disabled outputs tri-state unless software-driven
// - Disable clears counter, zeroes generator, keeps flags
// - Each fault maps to any output pins
// - Fault blocks pins only, counter keeps running
// - Faults latch while disabled unless pin off
// - Filter samples every four cycles, qualifies run
// - Fault sets flag; write one clears
// - Fault request holds until flag or enable cleared
// - Auto mode re-enables at half cycle when low
// - Manual faults 0,2 re-enable per qualifier
// - Manual faults 1,3 need clear and low
`timescale 1ns/1ps
`default_nettype none
module pwm_reload_and_fault_protect
   import pwm_reload_pkg::*;
#(
   parameter int unsigned CW = 16            // Counter width
)(
   input  wire logic                 clk_in,
   input  wire logic                 rst_n_in,
   input  wire logic                 ce_in,
   input  wire logic [7:0]           paddr_in,
   input  wire logic                 psel_in,
   input  wire logic                 penable_in,
   input  wire logic                 pwrite_in,
   input  wire logic [31:0]          pwdata_in,
   input  wire logic [NUM_FAULT-1:0] fault_input_in,
   output logic      [31:0]          prdata_out,
   output logic                      pready_out,
   output logic                      pslverr_out,
   output logic      [NUM_PIN-1:0]   pwm_out,
   output logic      [NUM_PIN-1:0]   pwm_oe_out,
   output logic      [NUM_GEN-1:0]   reload_irq_out,
   output logic                      fault_irq_out
);
   // Refuse widths the registers cannot hold
   if (CW < 4 || CW > 16) begin : g_bad_cw
      $error("CW must be 4 to 16");
   end

   // Software-written configuration
   logic                  en_q;          // generator_enable
   logic                  load_okay_q;        // load_okay
   logic                  half_q;        // Half-cycle reloads
   logic                  center_q;      // Center-aligned mode
   logic [3:0]            load_frequency_sel_q;        // load_frequency_sel
   logic [1:0]            prsc_q;        // Buffered prescaler
   logic [NUM_GEN-1:0]    rie_q;         // reload_irq_en
   logic                  corr_q;        // Current correction
   logic [CW-1:0]         mod_buf_q;     // Buffered modulus
   logic [CW-1:0]         val_buf_q [6]; // Buffered values
   logic [NUM_FAULT-1:0]  pinen_q;       // fault_pin_enable
   logic [NUM_FAULT-1:0]  fie_q;         // fault_irq_en
   logic [NUM_FAULT-1:0]  fauto_q;       // fault_auto_clear
   logic [7:0]            qual_q;        // fault_filter_qual
   logic [NUM_PIN*4-1:0]  dmap_q;        // Disable mapping
   logic [NUM_PIN-1:0]    swctl_q;       // sw_output_ctl
   logic [NUM_PIN-1:0]    swlvl_q;       // sw_output_level
   // Generator state
   logic [CW-1:0]         mod_act_q;     // Active modulus
   logic [CW-1:0]         val_act_q [6]; // Active values
   logic [1:0]            prsc_act_q;    // Active prescaler
   logic [3:0]            load_frequency_sel_act_q;    // Active frequency
   logic [3:0]            opp_cnt_q;     // Opportunities seen
   logic [2:0]            presc_q;       // Prescaler count
   logic [CW-1:0]         cnt_q;         // PWM counter
   logic                  up_q;          // Count direction
   logic                  first_q;       // No enable since reset
   logic                  fc_q;          // First cycle after enable
   logic [NUM_GEN-1:0]    rflag_q;       // reload_flag
   // Fault state
   logic [NUM_FAULT-1:0]  filt;          // Filtered fault levels
   logic [NUM_FAULT-1:0]  filt_d1_q;     // Delayed filtered level
   logic [NUM_FAULT-1:0]  fflag_q;       // fault_flag
   logic [NUM_FAULT-1:0]  lat_q;         // Latched pin disable
   // Bus handshake
   logic                  acc_q;         // Answer pending
   // Combinational terms
   logic                  wr;            // Write commits now
   logic [5:0]            widx;          // Word index of access
   logic                  en_rise;       // Enable being set
   logic                  tick;          // Prescaled count step
   logic [2:0]            plim;          // Prescaler last value
   logic                  start_ev;      // PWM cycle start
   logic                  half_ev;       // Count reaches modulus
   logic                  opp;           // Reload opportunity
   logic                  rl;            // Reload cycle
   logic                  ld_now;        // Transfer buffers now
   logic                  hb;            // Fault clear boundary
   logic [NUM_PIN-1:0]    gen;           // Generator outputs
   logic [NUM_PIN-1:0]    dis;           // Fault pin disables
   logic [31:0]           rd;            // Read data mux
   logic                  hit;           // Mapped address

   assign widx = paddr_in[7:2];
   assign wr   = psel_in & penable_in & acc_q & pwrite_in & hit;
   assign en_rise = wr & (paddr_in == OFS_CTRL)
                  & pwdata_in[CTRL_EN] & ~en_q;

   // APB read decode and mapped-address check
   always_comb begin
      rd  = 32'h0;
      hit = 1'b1;
      case (paddr_in)
         OFS_CTRL:  rd = {18'h0, corr_q, rie_q, prsc_q, load_frequency_sel_q,
                          center_q, half_q, load_okay_q, en_q};
         OFS_RFLAG: rd = {29'h0, rflag_q};
         OFS_MOD:   rd = {{(32-CW){1'b0}}, mod_buf_q};
         OFS_CNT:   rd = {{(32-CW){1'b0}}, cnt_q};
         OFS_FCTL:  rd = {12'h0, qual_q, fauto_q, fie_q, pinen_q};
         OFS_FFLAG: rd = {24'h0, filt, fflag_q};
         OFS_DMAP:  rd = {8'h0, dmap_q};
         OFS_OCTL:  rd = {18'h0, swlvl_q, 2'h0, swctl_q};
         default: begin
            // Value buffers occupy six consecutive words
            if (paddr_in[1:0] == 2'h0 && widx >= OFS_VAL0[7:2]
                && widx < OFS_VAL0[7:2] + 6'h6) begin
               rd = {{(32-CW){1'b0}},
                     val_buf_q[3'(widx - OFS_VAL0[7:2])]};
            end else begin
               hit = 1'b0;
            end
         end
      endcase
   end

   // APB answer: zero wait states, registered data
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         acc_q       <= 1'b0;
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= REG_RST;
      end else if (ce_in) begin
         acc_q       <= psel_in & ~penable_in;
         pready_out  <= psel_in & ~penable_in;
         pslverr_out <= psel_in & ~penable_in & ~hit;
         if (psel_in & ~penable_in & ~pwrite_in)
            prdata_out <= rd;
      end
   end

   // Configuration written by software
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         en_q      <= CTRL_RST[CTRL_EN];
         half_q    <= CTRL_RST[CTRL_HALF];
         center_q  <= CTRL_RST[CTRL_CENTER];
         load_frequency_sel_q    <= CTRL_RST[CTRL_LOAD_FREQUENCY_SEL_LSB +: 4];
         prsc_q    <= CTRL_RST[CTRL_PRSC_LSB +: 2];
         rie_q     <= CTRL_RST[CTRL_RIE_LSB +: NUM_GEN];
         corr_q    <= CTRL_RST[CTRL_CORR];
         mod_buf_q <= MOD_RST[CW-1:0];
         pinen_q   <= REG_RST[3:0];
         fie_q     <= REG_RST[3:0];
         fauto_q   <= REG_RST[3:0];
         qual_q    <= REG_RST[7:0];
         dmap_q    <= REG_RST[23:0];
         swctl_q   <= REG_RST[5:0];
         swlvl_q   <= REG_RST[5:0];
         for (int i = 0; i < 6; i++) val_buf_q[i] <= REG_RST[CW-1:0];
      end else if (ce_in && wr) begin
         case (paddr_in)
            OFS_CTRL: begin
               en_q     <= pwdata_in[CTRL_EN];
               half_q   <= pwdata_in[CTRL_HALF];
               center_q <= pwdata_in[CTRL_CENTER];
               load_frequency_sel_q   <= pwdata_in[CTRL_LOAD_FREQUENCY_SEL_LSB +: 4];
               prsc_q   <= pwdata_in[CTRL_PRSC_LSB +: 2];
               rie_q    <= pwdata_in[CTRL_RIE_LSB +: NUM_GEN];
               corr_q   <= pwdata_in[CTRL_CORR];
            end
            OFS_MOD:  mod_buf_q <= pwdata_in[CW-1:0];
            OFS_FCTL: begin
               pinen_q <= pwdata_in[FCTL_PINEN_LSB +: 4];
               fie_q   <= pwdata_in[FCTL_FIE_LSB +: 4];
               fauto_q <= pwdata_in[FCTL_AUTO_LSB +: 4];
               qual_q  <= pwdata_in[FCTL_QUAL_LSB +: 8];
            end
            OFS_DMAP: dmap_q <= pwdata_in[23:0];
            OFS_OCTL: begin
               swctl_q <= pwdata_in[5:0];
               swlvl_q <= pwdata_in[OCTL_LVL_LSB +: 6];
            end
            default: begin
               // Remaining hits are the value buffers
               if (paddr_in != OFS_RFLAG && paddr_in != OFS_CNT
                   && paddr_in != OFS_FFLAG)
                  val_buf_q[3'(widx - OFS_VAL0[7:2])] <=
                     pwdata_in[CW-1:0];
            end
         endcase
      end
   end

   // Timebase events
   assign plim  = 3'((4'h1 << prsc_act_q) - 4'h1);
   assign tick  = en_q & (presc_q == plim);
   assign half_ev  = tick & center_q & up_q
                   & (cnt_q == mod_act_q - CW'(1));
   assign start_ev = tick & (center_q ? (~up_q & cnt_q == CW'(1))
                                      : (cnt_q == mod_act_q - CW'(1)));
   assign opp = start_ev | (half_ev & half_q);
   assign rl  = opp & (opp_cnt_q == load_frequency_sel_act_q);
   assign ld_now = load_okay_q & (rl | en_rise);

   // Load okay: software sets, a transfer clears
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         load_okay_q <= CTRL_RST[CTRL_LOAD_OKAY];
      end else if (ce_in) begin
         if (wr && paddr_in == OFS_CTRL && pwdata_in[CTRL_LOAD_OKAY])
            load_okay_q <= 1'b1;
         else if (ld_now)
            load_okay_q <= 1'b0;
      end
   end

   // Prescaler and up/down counter
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         presc_q <= 3'h0;
         cnt_q   <= '0;
         up_q    <= 1'b1;
      end else if (ce_in) begin
         if (!en_q) begin
            presc_q <= 3'h0;
            cnt_q   <= '0;
            up_q    <= 1'b1;
         end else if (tick) begin
            presc_q <= 3'h0;
            if (half_ev && rl && load_okay_q) begin
               cnt_q <= mod_buf_q - CW'(1);
               up_q  <= 1'b0;
            end else if (center_q) begin
               if (up_q) begin
                  cnt_q <= cnt_q + CW'(1);
                  up_q  <= (cnt_q + CW'(1) != mod_act_q);
               end else begin
                  cnt_q <= cnt_q - CW'(1);
                  up_q  <= (cnt_q == CW'(1));
               end
            end else begin
               cnt_q <= start_ev ? '0 : cnt_q + CW'(1);
            end
         end else begin
            presc_q <= presc_q + 3'h1;
         end
      end
   end

   // Reload opportunity counting
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         opp_cnt_q  <= 4'h0;
         load_frequency_sel_act_q <= CTRL_RST[CTRL_LOAD_FREQUENCY_SEL_LSB +: 4];
      end else if (ce_in) begin
         if (!en_q) begin
            opp_cnt_q <= 4'h0;
         end else if (opp) begin
            load_frequency_sel_act_q <= load_frequency_sel_q;
            opp_cnt_q  <= rl ? 4'h0 : opp_cnt_q + 4'h1;
         end
      end
   end

   // Active parameters and first-enable defaults
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         mod_act_q  <= MOD_RST[CW-1:0];
         prsc_act_q <= CTRL_RST[CTRL_PRSC_LSB +: 2];
         first_q    <= 1'b1;
         for (int i = 0; i < 6; i++) val_act_q[i] <= REG_RST[CW-1:0];
      end else if (ce_in) begin
         if (en_rise)
            first_q <= 1'b0;
         if (ld_now) begin
            mod_act_q  <= mod_buf_q;
            prsc_act_q <= prsc_q;
            for (int i = 0; i < 6; i++) val_act_q[i] <= val_buf_q[i];
         end else if (en_rise && first_q) begin
            prsc_act_q <= 2'h0;
            for (int i = 0; i < 6; i++) val_act_q[i] <= '0;
         end
         // Re-enable without load okay keeps old values
      end
   end

   // Reload flags: set wins over write-one-to-clear
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rflag_q <= REG_RST[NUM_GEN-1:0];
         fc_q    <= 1'b0;
      end else if (ce_in) begin
         rflag_q <= (rflag_q & ~((wr && paddr_in == OFS_RFLAG)
                     ? pwdata_in[NUM_GEN-1:0] : 3'h0))
                  | {NUM_GEN{rl | en_rise}};
         if (en_rise)
            fc_q <= 1'b1;
         else if (start_ev || !en_q)
            fc_q <= 1'b0;
      end
   end

   // Generator outputs per complementary pair
   always_comb begin
      for (int p = 0; p < 3; p++) begin
         gen[2*p] = en_q & (cnt_q < ((corr_q & fc_q)
                    ? val_act_q[2*p+1] : val_act_q[2*p]));
         gen[2*p+1] = en_q & ~gen[2*p];
      end
   end

   // Fault input filters
   for (genvar f = 0; f < NUM_FAULT; f++) begin : g_filt
      fault_filter u_filt (
         .clk_in    (clk_in),
         .rst_n_in  (rst_n_in),
         .ce_in     (ce_in),
         .enable_in (pinen_q[f]),
         .qual_in   (qual_q[2*f +: 2]),
         .pin_in    (fault_input_in[f]),
         .fault_out (filt[f])
      );
   end

   // Half-cycle boundary, or every cycle while disabled
   assign hb = en_q ? (start_ev | half_ev) : 1'b1;

   // Fault flags and latched pin disables
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         filt_d1_q <= 4'h0;
         fflag_q   <= 4'h0;
         lat_q     <= 4'h0;
      end else if (ce_in) begin
         filt_d1_q <= filt;
         for (int f = 0; f < NUM_FAULT; f++) begin
            // Flag: detection beats a same-cycle clear
            if (filt[f] && !filt_d1_q[f])
               fflag_q[f] <= 1'b1;
            else if (wr && paddr_in == OFS_FFLAG && pwdata_in[f])
               fflag_q[f] <= 1'b0;
            // Pin disable latch
            if (!pinen_q[f])
               lat_q[f] <= 1'b0;
            else if (filt[f] && !filt_d1_q[f])
               lat_q[f] <= 1'b1;
            else if (fauto_q[f])
               lat_q[f] <= lat_q[f] & ~(~filt[f] & hb);
            else if (f % 2 == 0)
               lat_q[f] <= lat_q[f] & ~(~fflag_q[f]
                  & ((qual_q[2*f +: 2] == 2'h0) ? ~filt[f] : hb));
            else
               lat_q[f] <= lat_q[f]
                  & ~(~fflag_q[f] & ~filt[f] & hb);
         end
      end
   end

   // Fault mapping onto pins; generator untouched
   always_comb begin
      for (int i = 0; i < NUM_PIN; i++)
         dis[i] = |(lat_q & dmap_q[MAP_BITS*i +: MAP_BITS]);
   end

   // Registered pins and interrupt requests
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pwm_out        <= '0;
         pwm_oe_out     <= '0;
         reload_irq_out <= '0;
         fault_irq_out  <= 1'b0;
      end else if (ce_in) begin
         for (int i = 0; i < NUM_PIN; i++) begin
            // Drive only when enabled or software-driven
            pwm_oe_out[i] <= (en_q | swctl_q[i]) & ~dis[i];
            pwm_out[i]    <= (en_q | swctl_q[i]) & ~dis[i]
                           & (swctl_q[i] ? swlvl_q[i] : gen[i]);
         end
         reload_irq_out <= rflag_q & rie_q;
         fault_irq_out  <= |(fflag_q & fie_q);
      end
   end
endmodule // pwm_reload_and_fault_protect
`default_nettype wire

// ==== verif/pwm_prot_asserts.sv ====
/* Port checker for the PWM reload and fault block.
 Assumes ce_in held high and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module pwm_prot_asserts
   import pwm_reload_pkg::*;
(
   input wire logic               clk_in,
   input wire logic               rst_n_in,
   input wire logic [7:0]         paddr_in,
   input wire logic               psel_in,
   input wire logic               penable_in,
   input wire logic               pwrite_in,
   input wire logic [31:0]        pwdata_in,
   input wire logic               pready_out,
   input wire logic               pslverr_out,
   input wire logic [NUM_PIN-1:0] pwm_out,
   input wire logic [NUM_PIN-1:0] pwm_oe_out,
   input wire logic [NUM_GEN-1:0] reload_irq_out,
   input wire logic               fault_irq_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // Committing write cycle
   wire logic acc_w = psel_in & penable_in & pwrite_in;
   a_ready_after_setup: assert property (psel_in & !penable_in |=> pready_out)
      else $error("ready missing after setup");
   a_ready_one_cycle: assert property (pready_out |=> !pready_out)
      else $error("ready held too long");
   a_err_with_ready: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
   a_undriven_pin_low: assert property ((pwm_out & ~pwm_oe_out) == '0)
      else $error("undriven pin not low");
   a_fie_off_quiet: assert property (acc_w && paddr_in == OFS_FCTL
      && pwdata_in[7:4] == 4'h0 |=> ##1 !fault_irq_out)
      else $error("fault request kept after enable off");
   a_rie_off_quiet: assert property (acc_w && paddr_in == OFS_CTRL
      && pwdata_in[12:10] == 3'h0 |=> ##1 reload_irq_out == 3'h0)
      else $error("reload request kept after enable off");
   a_fault_irq_hold: assert property ($fell(fault_irq_out) |-> $past(acc_w, 2))
      else $error("fault request dropped by itself");
   a_reload_irq_hold: assert property
      (|($past(reload_irq_out) & ~reload_irq_out) |-> $past(acc_w, 2))
      else $error("reload request dropped by itself");
   c_fault_irq: cover property ($rose(fault_irq_out));
   c_reload_irq: cover property ($rose(reload_irq_out[0]));
   c_bus_err: cover property (pslverr_out);
endmodule // pwm_prot_asserts
bind pwm_reload_and_fault_protect pwm_prot_asserts pwm_prot_asserts_i (
   .clk_in, .rst_n_in, .paddr_in, .psel_in, .penable_in, .pwrite_in,
   .pwdata_in, .pready_out, .pslverr_out, .pwm_out, .pwm_oe_out,
   .reload_irq_out, .fault_irq_out);
`default_nettype wire

// ==== verif/fault_source.sv ====
/* Fault sensing model: drives the active-high fault pins.
 Assumes bench requests change just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module fault_source (
   input  wire logic       clk_in,
   input  wire logic [3:0] req_in,
   output var  logic [3:0] fault_out = 4'h0
);
   // Logic one on a pin reports a fault
   always @(posedge clk_in) fault_out <= req_in;
endmodule // fault_source
`default_nettype wire

// ==== verif/tb.sv ====
/* Self-checking bench: APB tasks, output and fault scenarios.
 Assumes the partner model drives the fault pins. */
`timescale 1ns/1ps
`default_nettype none
module tb import pwm_reload_pkg::*;;
   logic clk_in = 0, rst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
   logic [7:0]  paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0, prdata_out, r, ones;
   logic [3:0]  fault_req = 4'h0, fault_input_in;
   logic [5:0]  pwm_out, pwm_oe_out;
   logic [2:0]  reload_irq_out;
   logic        pready_out, pslverr_out, fault_irq_out, e;
   int          err_total = 0, total_checks = 0;
   always #2 clk_in = ~clk_in; // 250 MHz clock
   pwm_reload_and_fault_protect #(.CW(16)) pwm_reload_and_fault_protect_i (
      .clk_in, .rst_n_in, .ce_in(1'b1), .paddr_in, .psel_in, .penable_in,
      .pwrite_in, .pwdata_in, .fault_input_in, .prdata_out, .pready_out,
      .pslverr_out, .pwm_out, .pwm_oe_out, .reload_irq_out, .fault_irq_out);
   fault_source fault_source_i (.clk_in, .req_in(fault_req),
      .fault_out(fault_input_in));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer, held until ready is sampled high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, wr, a, d};
      @(posedge clk_in) penable_in <= 1'b1;
      // Wait for the answer; only the watchdog ends a hung wait
      do begin @(posedge clk_in); end while (pready_out !== 1'b1);
      r = prdata_out;
      e = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(r, exp);
   endtask
   task test_done;
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Watchdog against a hung run
   initial begin
      repeat (20000) @(posedge clk_in);
      err_total++;
      test_done;
   end
   // Main sequence
   initial begin
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(OFS_MOD, MOD_RST);
      apb(1'b0, 8'h40, 32'h0);
      chk(32'(e), 32'h1); // unmapped place refused
      chk(32'(pwm_oe_out), 32'h0);
      apb(1'b1, OFS_CTRL, 32'h1c01);
      rd(OFS_RFLAG, 32'h7);
      chk(32'(reload_irq_out), 32'h7);
      chk(32'(pwm_out), 32'h2a);
      apb(1'b1, OFS_CTRL, 32'h1c00);
      rd(OFS_RFLAG, 32'h7);
      chk(32'(reload_irq_out), 32'h7);
      rd(OFS_CNT, 32'h0);
      chk(32'(pwm_oe_out), 32'h0);
      chk(32'(pwm_out), 32'h0);
      apb(1'b1, OFS_CTRL, 32'h0);
      rd(OFS_RFLAG, 32'h7);
      chk(32'(reload_irq_out), 32'h0);
      apb(1'b1, OFS_RFLAG, 32'h7);
      rd(OFS_RFLAG, 32'h0);
      apb(1'b1, OFS_OCTL, 32'h153f);
      repeat (4) @(posedge clk_in);
      chk(32'(pwm_oe_out), 32'h3f);
      chk(32'(pwm_out), 32'h15);
      apb(1'b1, OFS_DMAP, 32'h8421);
      apb(1'b1, OFS_FCTL, 32'h00ff);
      for (int i = 0; i < 4; i++) begin
         fault_req[i] <= 1'b1;
         repeat (20) @(posedge clk_in);
         chk(32'(pwm_oe_out), 32'h3f & ~(32'h1 << i));
         chk(32'(fault_irq_out), 32'h1);
         rd(OFS_FFLAG, 32'h11 << i);
         fault_req[i] <= 1'b0;
         repeat (20) @(posedge clk_in);
         chk(32'(pwm_oe_out), 32'h3f & ~(32'h1 << i));
         apb(1'b1, OFS_FFLAG, 32'h1 << i);
         repeat (4) @(posedge clk_in);
         chk(32'(pwm_oe_out), 32'h3f);
         chk(32'(fault_irq_out), 32'h0);
      end
      apb(1'b1, OFS_FCTL, 32'h01ff);
      fault_req[0] <= 1'b1;
      repeat (20) @(posedge clk_in);
      fault_req[0] <= 1'b0;
      repeat (20) @(posedge clk_in);
      chk(32'(pwm_oe_out), 32'h3f);
      rd(OFS_FFLAG, 32'h1);
      apb(1'b1, OFS_FCTL, 32'h010f);
      repeat (3) @(posedge clk_in);
      chk(32'(fault_irq_out), 32'h0);
      // Fault 2 qualified by two samples: a one-cycle pulse is ignored
      apb(1'b1, OFS_FCTL, 32'h100ff);
      fault_req[2] <= 1'b1;
      @(posedge clk_in) fault_req[2] <= 1'b0;
      repeat (20) @(posedge clk_in);
      rd(OFS_FFLAG, 32'h1);
      fault_req[2] <= 1'b1;
      repeat (20) @(posedge clk_in);
      chk(32'(pwm_oe_out), 32'h3b);
      // Clearing the flag re-enables even with the pin still high
      apb(1'b1, OFS_FFLAG, 32'h4);
      repeat (4) @(posedge clk_in);
      chk(32'(pwm_oe_out), 32'h3f);
      fault_req[2] <= 1'b0;
      // Enable with load okay: modulus 4, value 1 loaded at once
      apb(1'b1, OFS_OCTL, 32'h0);
      apb(1'b1, OFS_MOD, 32'h4);
      apb(1'b1, OFS_VAL0, 32'h1);
      apb(1'b1, OFS_CTRL, 32'h2);
      apb(1'b1, OFS_CTRL, 32'h1);
      rd(OFS_CTRL, 32'h1);
      ones = 32'h0;
      repeat (8) @(posedge clk_in) ones = ones + pwm_out[0];
      chk(ones, 32'h2);
      test_done;
   end
endmodule // tb
`default_nettype wire
